// *** sim/sweep_engine_test.sv ***
// Self-checking testbench of the frequency sweep engine.
`timescale 1ns/1ps
`default_nettype none
module sweep_engine_test;
    import sweep_pkg::*;

    logic        clk;
    logic        rst;
    host_wr_t    host_wr;
    logic        ext_update;
    logic        keying_hold_pin;
    logic        update_strobe_pin;
    logic [47:0] tuning_out;
    logic [47:0] phase_acc;
    logic [13:0] phase_offset;
    logic [11:0] amplitude;
    logic [2:0]  mode_out;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;
    int          rate;
    int          n;
    logic [47:0] base;
    logic [47:0] delta;
    logic [47:0] held;
    logic [13:0] phase;
    logic [47:0] top_word;
    logic [47:0] acc_seen;
    logic [11:0] amult;

    sweep_engine u_dut (.clk(clk), .rst(rst), .host_wr(host_wr), .ext_update(ext_update),
        .keying_hold_pin(keying_hold_pin), .update_strobe_pin(update_strobe_pin),
        .tuning_out(tuning_out), .phase_acc(phase_acc), .phase_offset(phase_offset),
        .amplitude(amplitude), .mode_out(mode_out));

    sweep_host u_host (.clk(clk), .host_wr(host_wr), .ext_update(ext_update),
        .keying_hold_pin(keying_hold_pin));

    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    // --------------------------------------------------------------
    // Checking and closing
    // --------------------------------------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // Counts falling edges until tuning_out moves, bounded.
    task automatic wait_change(output int cnt);
        logic [47:0] v;
        v = tuning_out;
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (tuning_out === v && cnt < 200);
    endtask : wait_change

    // Model of the sweep: one step of delta every rate+1 cycles.
    task automatic step_check(input int r, input logic [47:0] d);
        logic [47:0] exp_q[$];
        int          c;
        wait_change(c);
        wait_change(c);
        for (int i = 1; i <= 3; i++) begin
            exp_q.push_back(tuning_out + 48'(i) * d);
        end
        while (exp_q.size() > 0) begin
            wait_change(c);
            check(48'(c), 48'(r + 1));
            check(tuning_out, exp_q.pop_front());
        end
    endtask : step_check

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        rst = 1'b1;
        void'($urandom(32'h51ae));
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(48'(mode_out), 48'h0);
        check(tuning_out, 48'h0);
        $display("test reset done");

        rate  = 3 + int'($urandom % 8);
        base  = 48'($urandom) << 8;
        delta = 48'($urandom % 32'h00ff_ffff) + 48'h1;
        phase = 14'($urandom);
        amult = 12'($urandom);
        // host loads start, step and rate
        u_host.put_word(OFS_BASE_TUNING, base, 6);
        u_host.put_word(OFS_STEP_DELTA, delta, 6);
        u_host.put_word(OFS_STEP_RATE, 48'(rate), 3);
        u_host.put_word(OFS_PHASE_ONE, 48'(phase), 2);
        u_host.put_word(OFS_AMPL_MULT, 48'(amult), 2);
        u_host.put_word(OFS_CONTROL, 48'h06, 1);
        check(48'(mode_out), 48'h0);
        n = 0;
        while (update_strobe_pin !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (update_strobe_pin === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(48'(n), 48'(UPD_PULSE_CYC));
        check(48'(mode_out), 48'(MODE_CHIRP));
        check(48'(phase_offset), 48'(phase));
        check(48'(amplitude), 48'(amult));
        $display("test internal update done");

        step_check(rate, delta);
        $display("test chirp slope done");

        rate = 3 + int'($urandom % 8);
        u_host.put_word(OFS_STEP_RATE, 48'(rate), 3);
        delta = -delta;
        u_host.put_word(OFS_STEP_DELTA, delta, 6);
        u_host.pulse_update();
        step_check(rate, delta);
        $display("test slope change done");

        // host holds after timing the sweep itself
        u_host.set_hold(1'b1);
        repeat (rate + 4) @(negedge clk);
        held = tuning_out;
        acc_seen = phase_acc;
        @(negedge clk);
        check(phase_acc, acc_seen + held);
        repeat (3 * (rate + 1) - 1) @(negedge clk);
        check(tuning_out, held);
        u_host.set_hold(1'b0);
        $display("test hold done");

        // sweep clear returns chirp to base
        u_host.put_word(OFS_CONTROL, 48'h46, 1);
        repeat (2) begin
            u_host.pulse_update();
            n = 0;
            while (tuning_out !== base && n < 20) begin
                @(negedge clk);
                n++;
            end
            check(tuning_out, base);
            repeat (3 * (rate + 1)) @(negedge clk);
        end
        $display("test sweep clear done");

        u_host.put_word(OFS_CONTROL, 48'h86, 1);
        u_host.pulse_update();
        repeat (4) @(negedge clk);
        check(phase_acc, 48'h0);
        repeat (5) @(negedge clk);
        check(phase_acc, 48'h0);
        u_host.put_word(OFS_CONTROL, 48'h06, 1);
        u_host.pulse_update();
        n = 0;
        while (tuning_out !== base && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(tuning_out, base);
        $display("test phase clear done");

        // host loads high word above low
        delta = -delta;
        top_word = base + 48'h3 * delta + 48'h1;
        u_host.set_hold(1'b1);
        u_host.put_word(OFS_STEP_DELTA, delta, 6);
        u_host.put_word(OFS_HIGH_TUNING, top_word, 6);
        u_host.put_word(OFS_CONTROL, 48'h84, 1);
        u_host.pulse_update();
        u_host.put_word(OFS_CONTROL, 48'h04, 1);
        u_host.pulse_update();
        repeat (6 * (rate + 1)) @(negedge clk);
        check(tuning_out, top_word);
        repeat (2 * (rate + 1)) @(negedge clk);
        check(tuning_out, top_word);
        u_host.set_hold(1'b0);
        wait_change(n);
        check(tuning_out, top_word - delta);
        repeat (5 * (rate + 1)) @(negedge clk);
        check(tuning_out, base);
        $display("test ramped keying done");
        report_and_stop();
    end
endmodule : sweep_engine_test
`default_nettype wire

// *** sim/sweep_host.sv ***
// Host model that writes sweep registers and drives the keying and update pins.
`timescale 1ns/1ps
`default_nettype none
module sweep_host
    import sweep_pkg::*;
(
    input  wire logic clk,
    output host_wr_t  host_wr,
    output logic      ext_update,
    output logic      keying_hold_pin
);
    initial begin
        host_wr         = '0;
        ext_update      = 1'b0;
        keying_hold_pin = 1'b0;
    end

    // Bytes go out most significant first; the idle bus shows inverted junk.
    task automatic put_word(input logic [5:0] addr, input logic [47:0] value, input int nbytes);
        logic [7:0] b;
        for (int i = 0; i < nbytes; i++) begin
            b = 8'(value >> (8 * (nbytes - 1 - i)));
            @(negedge clk);
            host_wr <= '{wr: 1'b1, addr: addr + 6'(i), data: b};
        end
        @(negedge clk);
        host_wr <= '{wr: 1'b0, addr: ~addr, data: ~b};
    endtask : put_word

    task automatic pulse_update();
        @(negedge clk);
        ext_update <= 1'b1;
        @(negedge clk);
        ext_update <= 1'b0;
    endtask : pulse_update

    task automatic set_hold(input logic level);
        @(negedge clk);
        keying_hold_pin <= level;
    endtask : set_hold
endmodule : sweep_host
`default_nettype wire

// *** src/down_counter.sv ***
// Reloading down-counter that emits one pulse each time it reaches zero.
`timescale 1ns/1ps
`default_nettype none
module down_counter
    import sweep_pkg::*;
#(
    parameter int W = 20
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         run,
    input  wire logic [W-1:0] load_value,
    output logic              tick
);
    typedef struct packed {
        logic [W-1:0] count;
        logic         tick;
    } cnt_state_t;

    cnt_state_t st;
    cnt_state_t next_st;

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (run) begin
            if (st.count == '0) begin
                next_st.tick  = 1'b1;
                next_st.count = load_value;
            end else begin
                next_st.count = st.count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : down_counter
`default_nettype wire

// *** src/sweep_engine.sv ***
// Frequency sweep engine: ramped keying, triangle sweep, chirp and update clock.
// How it works
// - Phase offset LSB is 360/16384 degrees.
// - Step-rate counter counts down, pulses at zero.
// - Each step pulse clocks frequency accumulator.
// - End dwell lasts while keying pin holds.
// - Step pulse adds delta word to accumulator.
// - Accumulated delta offsets selected tuning word.
// - Ramped keying stops counter at destination.
// - Triangle bit sweeps low-high-low continuously.
// - Delta and rate changes apply mid-ramp.
// - Sweep clear zeroes accumulator one clock.
// - Held sweep clear zeroes on each update.
// - Phase clear holds phase accumulator at zero.
// - Phase clear zeroes sweep; resume at base.
// - Chirp halts on hold pin or zero delta.
// - Internal update counter moves buffered writes.
// - Internal update drives strobe pin ten cycles.
// - Chirp keeps no destination; host times it.
// - Amplitude bits pick direct or auto shaping.
// - Three-bit mode field selects operation.
// - Writes buffered until an update event.
`timescale 1ns/1ps
`default_nettype none
module sweep_engine
    import sweep_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire host_wr_t    host_wr,
    input  wire logic        ext_update,
    input  wire logic        keying_hold_pin,
    output logic             update_strobe_pin,
    output logic [47:0]      tuning_out,
    output logic [47:0]      phase_acc,
    output logic [13:0]      phase_offset,
    output logic [11:0]      amplitude,
    output logic [2:0]       mode_out
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        regs_t       buf_regs;
        regs_t       act;
        logic [47:0] sweep_acc;
        logic [47:0] tuning;
        logic [47:0] phase;
        logic [31:0] upd_count;
        logic [3:0]  strobe_cnt;
        logic        strobe;
        logic        going_down;
        logic        sweep_clear_pend;
        logic [11:0] ampl_level;
        logic [11:0] ampl_out;
        logic [13:0] phase_off;
    } eng_state_t;

    eng_state_t st;
    eng_state_t next_st;

    logic        rate_run;
    logic        rate_tick;
    logic        ampl_tick;
    logic        update_evt;
    logic        upd_tick;
    logic [47:0] sum_low;
    logic [47:0] sum_high;
    logic [47:0] target;
    logic        at_dest;
    mode_t       mode;
    logic        triangle;
    logic        sweep_clear_bit;
    logic        phase_clear_bit;
    logic        int_update;
    logic        amplitude_keying_enable;
    logic        amplitude_auto_shape_bit;

    assign mode                     = mode_t'(st.act.control[BIT_MODE_LSB +: 3]);
    assign triangle                 = st.act.control[BIT_TRIANGLE];
    assign sweep_clear_bit          = st.act.control[BIT_SWEEP_CLEAR];
    assign phase_clear_bit          = st.act.control[BIT_PHASE_CLEAR];
    assign int_update               = st.act.control[BIT_INT_UPDATE];
    assign amplitude_keying_enable  = st.act.ampl_ctrl[BIT_AMPL_KEY_EN];
    assign amplitude_auto_shape_bit = st.act.ampl_ctrl[BIT_AMPL_AUTO];

    // ------------------------------------------------------------------
    // Sweep datapath
    // ------------------------------------------------------------------
    // tuning word sum
    assign sum_low  = st.act.low_tuning_word + st.sweep_acc;
    assign sum_high = st.act.high_tuning_word - st.sweep_acc;
    assign target   = keying_hold_pin ? st.act.high_tuning_word : st.act.low_tuning_word;
    assign at_dest  = keying_hold_pin ? (sum_low >= st.act.high_tuning_word)
                                      : (sum_high <= st.act.low_tuning_word);

    always_comb begin
        rate_run = 1'b0;
        case (mode)
            MODE_RAMPED: rate_run = triangle ? 1'b1 : !at_dest;
            MODE_CHIRP:  rate_run = !keying_hold_pin && (st.act.step_delta_word != '0);
            default:     rate_run = 1'b0;
        endcase
        if (phase_clear_bit) begin
            rate_run = 1'b0;
        end
    end

    down_counter #(.W(20)) u_step_rate (
        .clk        (clk),
        .rst        (rst),
        .run        (rate_run),
        .load_value (st.act.step_rate_count),
        .tick       (rate_tick)
    );

    down_counter #(.W(32)) u_update (
        .clk        (clk),
        .rst        (rst),
        .run        (int_update),
        .load_value (st.act.update_count),
        .tick       (upd_tick)
    );

    down_counter #(.W(8)) u_ampl_rate (
        .clk        (clk),
        .rst        (rst),
        .run        (amplitude_keying_enable && amplitude_auto_shape_bit),
        .load_value (st.act.ampl_rate),
        .tick       (ampl_tick)
    );

    assign update_evt = int_update ? upd_tick : ext_update;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Host byte writes into the port buffers.
        if (host_wr.wr) begin
            case (host_wr.addr)
                6'h00: next_st.buf_regs.phase_one[13:8]  = host_wr.data[5:0];
                6'h01: next_st.buf_regs.phase_one[7:0]   = host_wr.data;
                6'h02: next_st.buf_regs.phase_two[13:8]  = host_wr.data[5:0];
                6'h03: next_st.buf_regs.phase_two[7:0]   = host_wr.data;
                6'h1a: next_st.buf_regs.step_rate_count[19:16] = host_wr.data[3:0];
                6'h1b: next_st.buf_regs.step_rate_count[15:8]  = host_wr.data;
                6'h1c: next_st.buf_regs.step_rate_count[7:0]   = host_wr.data;
                6'h1f: next_st.buf_regs.control   = host_wr.data;
                6'h20: next_st.buf_regs.ampl_ctrl = host_wr.data;
                6'h21: next_st.buf_regs.ampl_mult[11:8] = host_wr.data[3:0];
                6'h22: next_st.buf_regs.ampl_mult[7:0]  = host_wr.data;
                6'h25: next_st.buf_regs.ampl_rate = host_wr.data;
                default: begin
                    if (host_wr.addr >= OFS_BASE_TUNING && host_wr.addr < OFS_HIGH_TUNING) begin
                        next_st.buf_regs.low_tuning_word[8*(5 - 3'(host_wr.addr - OFS_BASE_TUNING)) +: 8]
                            = host_wr.data;
                    end else if (host_wr.addr >= OFS_HIGH_TUNING && host_wr.addr < OFS_STEP_DELTA) begin
                        next_st.buf_regs.high_tuning_word[8*(5 - 3'(host_wr.addr - OFS_HIGH_TUNING)) +: 8]
                            = host_wr.data;
                    end else if (host_wr.addr >= OFS_STEP_DELTA && host_wr.addr < OFS_UPDATE_CNT) begin
                        next_st.buf_regs.step_delta_word[8*(5 - 3'(host_wr.addr - OFS_STEP_DELTA)) +: 8]
                            = host_wr.data;
                    end else if (host_wr.addr >= OFS_UPDATE_CNT && host_wr.addr < OFS_STEP_RATE) begin
                        next_st.buf_regs.update_count[8*(3 - 2'(host_wr.addr - OFS_UPDATE_CNT)) +: 8]
                            = host_wr.data;
                    end
                end
            endcase
        end

        // transfer on update, timed by counter or by the external update pin
        if (update_evt) begin
            next_st.act = st.buf_regs;
        end

        if (int_update && upd_tick) begin
            next_st.strobe_cnt = 4'(UPD_PULSE_CYC - 1);
            next_st.strobe     = 1'b1;
        end else if (st.strobe_cnt != '0) begin
            next_st.strobe_cnt = st.strobe_cnt - 1'b1;
        end else begin
            next_st.strobe = 1'b0;
        end

        if (rate_tick) begin
            next_st.sweep_acc = st.sweep_acc + st.act.step_delta_word;
        end

        if (mode == MODE_RAMPED && triangle) begin
            if (!st.going_down && sum_low >= st.act.high_tuning_word) begin
                next_st.going_down = 1'b1;
                next_st.sweep_acc  = '0;
            end else if (st.going_down && sum_high <= st.act.low_tuning_word) begin
                next_st.going_down = 1'b0;
                next_st.sweep_acc  = '0;
            end
        end else begin
            next_st.going_down = keying_hold_pin;
            // turn back from current frequency
            // The distance already ramped is mirrored so the output does not jump.
            if (mode == MODE_RAMPED && keying_hold_pin != st.going_down) begin
                if (keying_hold_pin ? (sum_high <= st.act.low_tuning_word)
                                    : (sum_low >= st.act.high_tuning_word)) begin
                    next_st.sweep_acc = '0;
                end else begin
                    next_st.sweep_acc = st.act.high_tuning_word - st.act.low_tuning_word
                                        - st.sweep_acc;
                end
            end
        end

        next_st.sweep_clear_pend = update_evt && st.buf_regs.control[BIT_SWEEP_CLEAR];
        if (st.sweep_clear_pend || (sweep_clear_bit && update_evt)) begin
            next_st.sweep_acc = '0;
        end

        // selected tuning word drives phase input
        case (mode)
            MODE_KEYING: next_st.tuning = target;
            MODE_RAMPED: begin
                if (triangle) begin
                    next_st.tuning = st.going_down ? sum_high : sum_low;
                end else if (keying_hold_pin != st.going_down) begin
                    next_st.tuning = st.tuning;
                end else if (at_dest) begin
                    next_st.tuning = target;
                end else begin
                    next_st.tuning = keying_hold_pin ? sum_low : sum_high;
                end
            end
            MODE_CHIRP:  next_st.tuning = sum_low;
            default:     next_st.tuning = st.act.low_tuning_word;
        endcase

        if (phase_clear_bit) begin
            next_st.phase     = '0;
            next_st.sweep_acc = '0;
            next_st.tuning    = '0;
        end else begin
            next_st.phase = st.phase + st.tuning;
        end

        next_st.phase_off = (mode == MODE_PHASE_KEY && keying_hold_pin)
                            ? st.act.phase_two : st.act.phase_one;

        if (!amplitude_keying_enable) begin
            next_st.ampl_out = AMPL_FULL;
        end else if (!amplitude_auto_shape_bit) begin
            next_st.ampl_out = st.act.ampl_mult;
        end else begin
            if (ampl_tick && st.ampl_level != st.act.ampl_mult) begin
                next_st.ampl_level = st.ampl_level + 1'b1;
            end
            next_st.ampl_out = st.ampl_level;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st                    <= '0;
            st.buf_regs.control   <= RST_CONTROL;
            st.act.control        <= RST_CONTROL;
            st.buf_regs.ampl_ctrl <= RST_AMPL_CTRL;
            st.act.ampl_ctrl      <= RST_AMPL_CTRL;
            st.buf_regs.update_count <= RST_UPDATE_CNT;
            st.act.update_count   <= RST_UPDATE_CNT;
            st.buf_regs.ampl_rate <= RST_AMPL_RATE;
            st.act.ampl_rate      <= RST_AMPL_RATE;
        end else begin
            st <= next_st;
        end
    end

    assign update_strobe_pin = st.strobe;
    assign tuning_out        = st.tuning;
    assign phase_acc         = st.phase;
    assign phase_offset      = st.phase_off;
    assign amplitude         = st.ampl_out;
    assign mode_out          = st.act.control[BIT_MODE_LSB +: 3];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_phase_clear;
        @(posedge clk) disable iff (rst) phase_clear_bit |=> (phase_acc == '0);
    endproperty
    a_phase_clear: assert property (p_phase_clear) else $error("phase not held at zero");

    property p_sweep_zero;
        @(posedge clk) disable iff (rst) phase_clear_bit |=> (st.sweep_acc == '0);
    endproperty
    a_sweep_zero: assert property (p_sweep_zero) else $error("sweep not zeroed");

    property p_strobe_len;
        @(posedge clk) disable iff (rst)
            (int_update && upd_tick) |=> update_strobe_pin [*5] ##1 update_strobe_pin [*5];
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe shorter than ten");

    property p_chirp_hold;
        @(posedge clk) disable iff (rst)
            (mode == MODE_CHIRP && keying_hold_pin && !phase_clear_bit) |=> !rate_tick;
    endproperty
    a_chirp_hold: assert property (p_chirp_hold) else $error("chirp ran while held");

    property p_step_add;
        @(posedge clk) disable iff (rst)
            (rate_tick && !phase_clear_bit && !update_evt && !st.sweep_clear_pend
             && !(mode == MODE_RAMPED && triangle)
             && !(mode == MODE_RAMPED && keying_hold_pin != st.going_down))
            |=> (st.sweep_acc == $past(st.sweep_acc) + $past(st.act.step_delta_word));
    endproperty
    a_step_add: assert property (p_step_add) else $error("delta not added");

    property p_dest_stop;
        @(posedge clk) disable iff (rst)
            (mode == MODE_RAMPED && !triangle && at_dest) |=> !rate_tick;
    endproperty
    a_dest_stop: assert property (p_dest_stop) else $error("counter ran at destination");

    property p_buffered;
        @(posedge clk) disable iff (rst) (!update_evt) |=> (st.act == $past(st.act));
    endproperty
    a_buffered: assert property (p_buffered) else $error("active changed without update");

    property p_clear_pulse;
        @(posedge clk) disable iff (rst) st.sweep_clear_pend |=> (st.sweep_acc == '0);
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("sweep clear missed");

    c_ramp_tick:  cover property (@(posedge clk) mode == MODE_RAMPED && rate_tick);
    c_chirp_step: cover property (@(posedge clk) mode == MODE_CHIRP && rate_tick);
    c_strobe:     cover property (@(posedge clk) $rose(update_strobe_pin));
    c_triangle:   cover property (@(posedge clk) triangle && $rose(st.going_down));
endmodule : sweep_engine
`default_nettype wire

// *** src/sweep_pkg.sv ***
// Shared constants and carrier types of the frequency sweep engine.
package sweep_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] OFS_PHASE_ONE   = 6'h00;
    localparam logic [5:0] OFS_PHASE_TWO   = 6'h02;
    localparam logic [5:0] OFS_BASE_TUNING = 6'h04;
    localparam logic [5:0] OFS_HIGH_TUNING = 6'h0a;
    localparam logic [5:0] OFS_STEP_DELTA  = 6'h10;
    localparam logic [5:0] OFS_UPDATE_CNT  = 6'h16;
    localparam logic [5:0] OFS_STEP_RATE   = 6'h1a;
    localparam logic [5:0] OFS_CONTROL     = 6'h1f;
    localparam logic [5:0] OFS_AMPL_CTRL   = 6'h20;
    localparam logic [5:0] OFS_AMPL_MULT   = 6'h21;
    localparam logic [5:0] OFS_AMPL_RATE   = 6'h25;
    localparam logic [5:0] OFS_LAST        = 6'h27;

    // ------------------------------------------------------------------
    // Control byte fields at 1f and 20
    // ------------------------------------------------------------------
    localparam int BIT_PHASE_CLEAR   = 7;
    localparam int BIT_SWEEP_CLEAR   = 6;
    localparam int BIT_TRIANGLE      = 5;
    localparam int BIT_MODE_LSB      = 1;
    localparam int BIT_INT_UPDATE    = 0;
    localparam int BIT_AMPL_KEY_EN   = 5;
    localparam int BIT_AMPL_AUTO     = 4;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_CONTROL     = 8'h01;
    localparam logic [7:0]  RST_AMPL_CTRL   = 8'h20;
    localparam logic [31:0] RST_UPDATE_CNT  = 32'h0000_0040;
    localparam logic [7:0]  RST_AMPL_RATE   = 8'h80;
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          UPD_PULSE_CYC   = 10;
    localparam int          PHASE_STEPS     = 16384;
    localparam logic [11:0] AMPL_FULL       = 12'hfff;

    typedef enum logic [2:0] {
        MODE_SINGLE,
        MODE_KEYING,
        MODE_RAMPED,
        MODE_CHIRP,
        MODE_PHASE_KEY
    } mode_t;

    // Programming register image, buffered and active copies.
    typedef struct packed {
        logic [13:0] phase_one;
        logic [13:0] phase_two;
        logic [47:0] low_tuning_word;
        logic [47:0] high_tuning_word;
        logic [47:0] step_delta_word;
        logic [31:0] update_count;
        logic [19:0] step_rate_count;
        logic [7:0]  control;
        logic [7:0]  ampl_ctrl;
        logic [11:0] ampl_mult;
        logic [7:0]  ampl_rate;
    } regs_t;

    // Host write strobe with its byte.
    typedef struct packed {
        logic       wr;
        logic [5:0] addr;
        logic [7:0] data;
    } host_wr_t;

endpackage : sweep_pkg
